/* File: pkg/wia_consts.svh */
// Behaviour
// RL1: Incoming samples are averaged over a programmable count of 1 to 255 samples.
// RL2: The averaging window size is programmable from 1 to 65535 display counts.
// RL3: While each new sample stays inside the window, averaging continues over the set count.
// RL4: A sample outside the window is passed straight to the output instead of the average.
// RL5: After an excursion a fresh window is set up and averaging restarts within it.
// RL6: Each channel keeps its own sample count and window size, chosen by a selector.
// RL7: An out-of-window sample centres the new window on itself and clears the average.
`ifndef WIA_CONSTS_SVH
`define WIA_CONSTS_SVH

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define WIA_NCH 4
`define WIA_CHW 2
`define WIA_DW 32
`define WIA_HIST 256
`define WIA_HW 8
`define WIA_FIFO_DEPTH 32
`define WIA_FIFO_AW 5
`define WIA_CNT_RST 8'h01
`define WIA_WIN_RST 16'h0001

`endif

/* File: pkg/wia_pkg.sv */
`include "wia_consts.svh"
package wia_pkg;
    // Sample on the data path
    typedef struct packed {
        logic [`WIA_CHW-1:0] chan;
        logic signed [`WIA_DW-1:0] value;
    } wia_sample_type;
    // Per-channel averaging settings
    typedef struct packed {
        logic [`WIA_CHW-1:0] chan;
        logic [7:0] sample_count_setting;
        logic [15:0] window_size_setting;
    } wia_cfg_type;
    // Filter result
    typedef struct packed {
        logic [`WIA_CHW-1:0] chan;
        logic signed [`WIA_DW-1:0] value;
        logic raw;
    } wia_result_type;
    typedef enum logic [2:0] {
        WIA_IDLE = 3'b001,
        WIA_READ = 3'b010,
        WIA_CALC = 3'b100
    } wia_state_type;
endpackage

/* File: hdl/wia_fifo.sv */
`timescale 1ns/1ps
module wia_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic [AW:0] wp_nxt;
    logic [AW:0] rp_nxt;
    logic in_ready_r;
    logic full;
    logic empty;

    // Extra pointer bit tells full from empty
    assign empty = (wp_r == rp_r);
    assign full = !in_ready_r;
    // Ready is a flop of its own, so the source never sees a gate chain on it
    assign in_ready = in_ready_r;
    assign out_valid = !empty;
    assign out_data = mem[rp_r[AW-1:0]];

    // Next pointers, shared by the pointer flops and the ready flag
    assign wp_nxt = (in_valid && !full) ? wp_r + 1'b1 : wp_r;
    assign rp_nxt = (out_ready && !empty) ? rp_r + 1'b1 : rp_r;

    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            in_ready_r <= 1'b1;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            in_ready_r <= !((wp_nxt[AW] != rp_nxt[AW]) && (wp_nxt[AW-1:0] == rp_nxt[AW-1:0]));
        end
    end
endmodule

/* File: hdl/wia_averager.sv */
`timescale 1ns/1ps
`include "wia_consts.svh"
module wia_averager (
    input wire logic clk,
    input wire logic rst,
    input wire logic cfg_write,
    input wire wia_pkg::wia_cfg_type cfg_in,
    input wire logic in_valid,
    output logic in_ready,
    input wire wia_pkg::wia_sample_type in_sample,
    output logic out_valid,
    input wire logic out_ready,
    output wia_pkg::wia_result_type out_result
);
    import wia_pkg::*;

    // ----------------------------------------
    // Input buffer
    // ----------------------------------------
    wia_sample_type fifo_q;
    logic fifo_valid;
    logic fifo_take;

    wia_fifo #(
        .WIDTH($bits(wia_sample_type)),
        .DEPTH(`WIA_FIFO_DEPTH),
        .AW(`WIA_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_sample),
        .out_valid(fifo_valid),
        .out_ready(fifo_take),
        .out_data(fifo_q)
    );

    // ----------------------------------------
    // Per-channel settings and state
    // ----------------------------------------
    logic [7:0] cnt_set_r [`WIA_NCH];
    logic [15:0] win_set_r [`WIA_NCH];
    logic signed [`WIA_DW-1:0] centre_r [`WIA_NCH];
    logic signed [`WIA_DW+8:0] sum_r [`WIA_NCH];
    logic [7:0] fill_r [`WIA_NCH];
    logic [`WIA_HW-1:0] head_r [`WIA_NCH];
    logic signed [`WIA_DW-1:0] hist_r [`WIA_NCH][`WIA_HIST];

    wia_state_type state_r;
    wia_sample_type cur_r;
    logic signed [`WIA_DW-1:0] oldest_r;
    logic out_valid_r;
    wia_result_type out_r;

    assign out_valid = out_valid_r;
    assign out_result = out_r;
    // Stall the FIFO until the result slot is free, so back-pressure reaches the source
    assign fifo_take = (state_r == WIA_IDLE) && fifo_valid && (!out_valid_r || out_ready);

    // Zero settings are clamped to one so the divider never sees zero
    function automatic logic [7:0] clamp_cnt(input logic [7:0] v);
        return (v == 8'h00) ? 8'h01 : v;
    endfunction

    function automatic logic [15:0] clamp_win(input logic [15:0] v);
        return (v == 16'h0000) ? 16'h0001 : v;
    endfunction

    // Configuration per channel, selected by the channel field
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `WIA_NCH; i++) begin
                cnt_set_r[i] <= `WIA_CNT_RST;
                win_set_r[i] <= `WIA_WIN_RST;
            end
        end else if (cfg_write) begin
            cnt_set_r[cfg_in.chan] <= clamp_cnt(cfg_in.sample_count_setting); // [RL1] [RL6]
            win_set_r[cfg_in.chan] <= clamp_win(cfg_in.window_size_setting); // [RL2] [RL6]
        end
    end

    // ----------------------------------------
    // Filter sequence
    // ----------------------------------------
    logic [`WIA_CHW-1:0] ch;
    logic signed [`WIA_DW:0] diff;
    logic [`WIA_DW:0] adiff;
    logic outside;
    logic [7:0] n;
    logic full_win;
    logic signed [`WIA_DW+8:0] sum_nxt;
    logic [7:0] fill_nxt;

    // Window test and running sum for the current sample
    always_comb begin
        ch = cur_r.chan;
        diff = {cur_r.value[`WIA_DW-1], cur_r.value} - {centre_r[ch][`WIA_DW-1], centre_r[ch]};
        adiff = diff[`WIA_DW] ? -diff : diff;
        // Distance beyond half the window means the sample left it
        outside = (fill_r[ch] != 8'h00) && (adiff > {18'h00000, win_set_r[ch][15:1]});
        n = cnt_set_r[ch];
        full_win = (fill_r[ch] >= n);
        fill_nxt = fill_r[ch];
        if (outside || fill_r[ch] == 8'h00) begin
            sum_nxt = (`WIA_DW+9)'(cur_r.value); // [RL7]
            fill_nxt = 8'h01;
        end else if (full_win) begin
            // Oldest sample drops out when the count is reached
            sum_nxt = sum_r[ch] + (`WIA_DW+9)'(cur_r.value) - (`WIA_DW+9)'(oldest_r); // [RL3]
            fill_nxt = n;
        end else begin
            sum_nxt = sum_r[ch] + (`WIA_DW+9)'(cur_r.value); // [RL3]
            fill_nxt = fill_r[ch] + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= WIA_IDLE;
            cur_r <= '0;
            oldest_r <= '0;
        end else begin
            unique case (state_r)
                WIA_IDLE: begin
                    if (fifo_take) begin
                        cur_r <= fifo_q;
                        state_r <= WIA_READ;
                    end
                end
                WIA_READ: begin
                    // Sample leaving the average sits n entries behind the head
                    oldest_r <= hist_r[ch][head_r[ch] - n];
                    state_r <= WIA_CALC;
                end
                WIA_CALC: begin
                    state_r <= WIA_IDLE;
                end
            endcase
        end
    end

    // History, sums and window centre; reset clears the fill so stale history is ignored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `WIA_NCH; i++) begin
                sum_r[i] <= '0;
                fill_r[i] <= 8'h00;
                head_r[i] <= '0;
                centre_r[i] <= '0;
            end
        end else begin
            if (state_r == WIA_CALC) begin
                sum_r[ch] <= sum_nxt;
                fill_r[ch] <= fill_nxt;
                head_r[ch] <= head_r[ch] + 1'b1;
                if (outside || fill_r[ch] == 8'h00) begin
                    centre_r[ch] <= cur_r.value; // [RL5] [RL7]
                end
            end
            // New settings restart the channel, so a smaller count never divides a larger sum
            if (cfg_write) begin
                fill_r[cfg_in.chan] <= 8'h00; // [RL1] [RL3]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (state_r == WIA_CALC) begin
            hist_r[ch][head_r[ch]] <= cur_r.value;
        end
    end

    // Result register: raw value on excursion, else the average
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_valid_r <= 1'b0;
            out_r <= '0;
        end else begin
            if (state_r == WIA_CALC) begin
                out_valid_r <= 1'b1;
                out_r.chan <= ch;
                out_r.raw <= outside;
                if (outside) begin
                    out_r.value <= cur_r.value; // [RL4]
                end else begin
                    out_r.value <= `WIA_DW'(sum_nxt / $signed({1'b0, fill_nxt})); // [RL1] [RL3]
                end
            end else if (out_ready) begin
                out_valid_r <= 1'b0;
            end
        end
    end
endmodule

/* File: tb/wia_averager_asserts.sv */
`timescale 1ns/1ps
module wia_averager_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic cfg_write,
    input wire wia_pkg::wia_cfg_type cfg_in,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire wia_pkg::wia_sample_type in_sample,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire wia_pkg::wia_result_type out_result
);
    import wia_pkg::*;
    logic [7:0] pend_r;
    wia_sample_type last_r;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Samples in flight, so a lone result can be tied to its own sample
    always_ff @(posedge clk or posedge rst) begin
        if (rst) pend_r <= 8'h00;
        else pend_r <= pend_r + 8'(in_valid && in_ready) - 8'(out_valid && out_ready);
    end
    always_ff @(posedge clk) begin
        if (in_valid && in_ready) last_r <= in_sample;
    end
    // --------------------------------
    // Output handshake and content
    // --------------------------------
    chk_hold_valid: assert property (out_valid && !out_ready |=> out_valid)
        else $error("result withdrawn");
    chk_hold_value: assert property (out_valid && !out_ready |=> $stable(out_result))
        else $error("result changed while waiting");
    chk_no_spurious: assert property ($rose(out_valid) |-> pend_r != 8'h00)
        else $error("result without sample");
    chk_answer_time: assert property (
        in_valid && in_ready && pend_r == 8'h00 |-> ##[3:5] out_valid)
        else $error("result late");
    chk_idle_ready: assert property (pend_r == 8'h00 |-> in_ready)
        else $error("empty block refuses");
    chk_one_result: assert property (
        out_valid && out_ready && pend_r == 8'h01 |=> !out_valid)
        else $error("extra result");
    chk_raw_echo: assert property (
        out_valid && out_result.raw && pend_r == 8'h01 |-> out_result.value == last_r.value)
        else $error("raw result is not the sample");
    chk_chan_echo: assert property (
        out_valid && pend_r == 8'h01 |-> out_result.chan == last_r.chan)
        else $error("result on wrong channel");
endmodule
bind wia_averager wia_averager_asserts u_chk (.clk, .rst, .cfg_write, .cfg_in, .in_valid,
    .in_ready, .in_sample, .out_valid, .out_ready, .out_result);

/* File: tb/wia_src.sv */
`timescale 1ns/1ps
module wia_src (
    input wire logic clk,
    input wire logic in_ready,
    output logic in_valid,
    output wia_pkg::wia_sample_type in_sample
);
    import wia_pkg::*;
    initial begin
        in_valid = 1'b0;
        in_sample = '0;
    end
    // Offer one sample, hold it until taken, scramble the released data, let one edge pass
    task automatic send(input logic [1:0] ch, input int v, output logic ok);
        int n;
        n = 0;
        in_valid = 1'b1;
        in_sample = '{chan: ch, value: v};
        while (!in_ready && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        in_valid = 1'b0;
        in_sample = ~in_sample;
        ok = n < 50;
        @(posedge clk);
        #1;
    endtask
endmodule

/* File: tb/test_windowed_input_averager.sv */
`timescale 1ns/1ps
module test_windowed_input_averager;
    import wia_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_write = 1'b0;
    logic out_ready = 1'b0;
    logic in_valid, in_ready, out_valid, ok;
    wia_cfg_type cfg_in = '0;
    wia_sample_type in_sample;
    wia_result_type out_result, r;
    int error_cnt = 0;
    int tests_run = 0;
    int k;
    always #5 clk = ~clk;
    wia_averager uut (.clk, .rst, .cfg_write, .cfg_in, .in_valid, .in_ready, .in_sample,
        .out_valid, .out_ready, .out_result);
    wia_src src (.clk, .in_ready, .in_valid, .in_sample);
    // --------------------------------
    // Shared tasks
    // --------------------------------
    task automatic check(input logic [34:0] seen, input logic [34:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("errors %0d, checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cfg(input logic [1:0] ch, input logic [7:0] c, input logic [15:0] w);
        cfg_in = '{chan: ch, sample_count_setting: c, window_size_setting: w};
        cfg_write = 1'b1;
        @(posedge clk);
        #1;
        cfg_write = 1'b0;
    endtask
    // Accept one result; the bounded wait ends the run on a hang
    task automatic get;
        int n;
        n = 0;
        out_ready = 1'b1;
        while (!out_valid && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 50) begin
            error_cnt++;
            results();
        end
        r = out_result;
        @(posedge clk);
        #1;
        out_ready = 1'b0;
    endtask
    task automatic xfer(input logic [1:0] ch, input int v, input int e, input logic raw);
        src.send(ch, v, ok);
        if (!ok) begin
            error_cnt++;
            results();
        end
        get();
        check(r, {ch, e, raw});
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_average;
        cfg(2'd0, 8'h04, 16'h0064);
        xfer(2'd0, 10, 10, 1'b0);
        xfer(2'd0, 20, 15, 1'b0);
        xfer(2'd0, 30, 20, 1'b0);
        xfer(2'd0, 40, 25, 1'b0);
        xfer(2'd0, 50, 35, 1'b0);
    endtask
    task automatic t_excursion;
        xfer(2'd0, 200, 200, 1'b1);
        xfer(2'd0, 210, 205, 1'b0);
        xfer(2'd0, 250, 220, 1'b0);
        xfer(2'd0, 251, 251, 1'b1);
    endtask
    task automatic t_channels;
        cfg(2'd1, 8'h01, 16'hFFFF);
        xfer(2'd1, 1000, 1000, 1'b0);
        xfer(2'd1, -1000, -1000, 1'b0);
        cfg(2'd2, 8'hFF, 16'h000A);
        xfer(2'd2, 7, 7, 1'b0);
        xfer(2'd2, 8, 7, 1'b0);
        xfer(2'd0, 261, 256, 1'b0);
    endtask
    // Consumer stalls until the input side refuses, then drains all
    task automatic t_fill;
        cfg(2'd3, 8'h01, 16'hFFFF);
        k = 0;
        while (in_ready && k < 40) begin
            src.send(2'd3, 5, ok);
            k++;
        end
        check({34'h0, in_ready}, 35'h0);
        repeat (k) begin
            get();
            check(r, {2'd3, 32'sd5, 1'b0});
        end
        check({34'h0, in_ready}, 35'h1);
    endtask
    // Mid-run reset restores default settings and empty histories
    task automatic t_reset;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check({34'h0, out_valid}, 35'h0);
        check({34'h0, in_ready}, 35'h1);
        check(out_result, 35'h0);
        rst = 1'b0;
        xfer(2'd0, 100, 100, 1'b0);
        xfer(2'd0, 300, 300, 1'b1);
        cfg(2'd1, 8'h00, 16'h0000);
        xfer(2'd1, 40, 40, 1'b0);
        xfer(2'd1, 40, 40, 1'b0);
        xfer(2'd1, 41, 41, 1'b1);
        cfg(2'd1, 8'h02, 16'h0064);
        xfer(2'd1, 60, 60, 1'b0);
        xfer(2'd1, 70, 65, 1'b0);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        t_average();
        t_excursion();
        t_channels();
        t_fill();
        t_reset();
        results();
    end
endmodule
